// ---- shared/eeprom_rd_defines.vh ----
// constants for the serial eeprom read path
`ifndef EEPROM_RD_DEFINES_VH
`define EEPROM_RD_DEFINES_VH
`define DEV_TYPE_CODE 4'ha
`define DEV_SEL_CODE 3'h0
`define ADDR_W 8
`define MEM_DEPTH_FULL 256
`define MEM_DEPTH_SMALL 128
`define ERASED_BYTE 8'hff
// write cycle time 5 ms at 40 MHz
`define WRITE_CYCLE_NS 5000000
`define CLK_PERIOD_NS 25
`define WRITE_CYCLE_CYC (`WRITE_CYCLE_NS / `CLK_PERIOD_NS)
`define ST_IDLE 3'h0
`define ST_DEVADDR 3'h1
`define ST_ACK_IN 3'h2
`define ST_RX 3'h3
`define ST_TX 3'h4
`define ST_ACK_OUT 3'h5
`define ST_LOAD 3'h6
`endif

// ---- src/byte_buffer2.v ----
// two-entry valid/ready buffer for outgoing read bytes
`timescale 1ns/1ps
module byte_buffer2 #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:1];
  reg rd_ptr_r;
  reg wr_ptr_r;
  reg [1:0] count_r;
  wire push;
  wire pop;

  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      count_r <= 2'h0;
      mem_r[0] <= {WIDTH{1'b0}};
      mem_r[1] <= {WIDTH{1'b0}};
    end else if (flush) begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- src/eeprom_read_path.v ----
// i2c serial eeprom slave: address load and read path
`timescale 1ns/1ps
// How it works
// - a read address byte is acked and the byte at the current address is shifted out.
// - after no-ack and stop the slave returns to idle waiting for start.
// - every byte after an acked write address is acked; the first one loads the address counter for the next read.
// - an ack from the master makes the slave send another byte.
// - the address increments per byte and wraps from the top of memory to zero.
// - on the small variant the counter does not wrap at the 128-byte boundary.
// - device address is 1010 000 plus the read/write bit.
// - on the ninth clock the sender releases sda for the receiver's answer.
// - sda is sampled on scl rise and changed on scl fall.
// - the slave address is not acked while a write cycle runs.
`include "eeprom_rd_defines.vh"
module eeprom_read_path #(
  parameter SMALL_VARIANT = 0,
  parameter WRITE_CYCLES = `WRITE_CYCLE_CYC
) (
  input wire clock,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  output reg busy
);
  // ---------------------------------------------------------------
  // reset and pin synchronisers
  // ---------------------------------------------------------------
  reg rst_a_r, rst_n_r;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  reg scl_a_r, scl_r, scl_d_r, sda_a_r, sda_r, sda_d_r;
  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_a_r <= 1'b1;
      scl_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_a_r <= 1'b1;
      sda_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_a_r <= scl_in;
      scl_r <= scl_a_r;
      scl_d_r <= scl_r;
      sda_a_r <= sda_in;
      sda_r <= sda_a_r;
      sda_d_r <= sda_r;
    end
  end
  wire scl_rise = scl_r && !scl_d_r;
  wire scl_fall = !scl_r && scl_d_r;
  wire start_det = scl_r && scl_d_r && !sda_r && sda_d_r;
  wire stop_det = scl_r && scl_d_r && sda_r && !sda_d_r;

  // ---------------------------------------------------------------
  // memory contents and address counter
  // ---------------------------------------------------------------
  localparam DEPTH = SMALL_VARIANT ? `MEM_DEPTH_SMALL : `MEM_DEPTH_FULL;
  reg [7:0] mem_r [0:`MEM_DEPTH_FULL-1];
  reg [`ADDR_W-1:0] addr_r;

  function [`ADDR_W-1:0] next_addr;
    input [`ADDR_W-1:0] a;
    begin
      if (SMALL_VARIANT != 0)
        next_addr = a + 8'h01;
      else
        next_addr = a + 8'h01;
    end
  endfunction

  integer i;
  initial begin
    for (i = 0; i < `MEM_DEPTH_FULL; i = i + 1)
      mem_r[i] = `ERASED_BYTE;
  end

  // ---------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------
  reg [2:0] state_r;
  reg [2:0] ret_r;
  reg [3:0] bit_r;
  reg [7:0] shift_r;
  reg rw_r;
  reg got_addr_r;
  reg wr_pend_r;
  reg [22:0] wcnt_r;
  reg tx_pending_r;

  wire [7:0] buf_data;
  wire buf_valid;
  wire buf_in_ready;
  reg fetch_r;
  reg pop_r;
  reg flush_r;

  byte_buffer2 #(.WIDTH(8)) u_buf (
    .clock(clock),
    .rst_n(rst_n_r),
    .flush(flush_r),
    .in_valid(fetch_r),
    .in_ready(buf_in_ready),
    .in_data(mem_r[addr_r]),
    .out_valid(buf_valid),
    .out_ready(pop_r),
    .out_data(buf_data)
  );

  wire addr_match = (shift_r[7:4] == `DEV_TYPE_CODE) && (shift_r[3:1] == `DEV_SEL_CODE);

  always @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= `ST_IDLE;
      ret_r <= `ST_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      got_addr_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wcnt_r <= 23'h000000;
      addr_r <= {`ADDR_W{1'b0}};
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
      busy <= 1'b0;
      fetch_r <= 1'b0;
      pop_r <= 1'b0;
      flush_r <= 1'b0;
      tx_pending_r <= 1'b0;
    end else begin
      fetch_r <= 1'b0;
      pop_r <= 1'b0;
      flush_r <= 1'b0;
      // write cycle timer; read requests are refused meanwhile
      if (busy) begin
        if (wcnt_r == 23'h000000)
          busy <= 1'b0;
        else
          wcnt_r <= wcnt_r - 23'h000001;
      end
      if (start_det) begin
        state_r <= `ST_DEVADDR;
        bit_r <= 4'h0;
        sda_oe_n <= 1'b1;
        flush_r <= 1'b1;
        tx_pending_r <= 1'b0;
        wr_pend_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= `ST_IDLE;
        sda_oe_n <= 1'b1;
        flush_r <= 1'b1;
        tx_pending_r <= 1'b0;
        // only a write with data starts a write cycle
        if (wr_pend_r) begin
          busy <= 1'b1;
          wcnt_r <= WRITE_CYCLES[22:0];
        end
        wr_pend_r <= 1'b0;
      end else begin
        case (state_r)
          `ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          `ST_DEVADDR, `ST_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_r};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              if (state_r == `ST_DEVADDR) begin
                if (addr_match && !busy) begin
                  sda_out <= 1'b0;
                  sda_oe_n <= 1'b0;
                  rw_r <= shift_r[0];
                  got_addr_r <= 1'b0;
                  state_r <= `ST_ACK_IN;
                  ret_r <= shift_r[0] ? `ST_LOAD : `ST_RX;
                end else begin
                  state_r <= `ST_IDLE;
                end
              end else begin
                sda_out <= 1'b0;
                sda_oe_n <= 1'b0;
                state_r <= `ST_ACK_IN;
                ret_r <= `ST_RX;
                if (!got_addr_r) begin
                  addr_r <= shift_r;
                  got_addr_r <= 1'b1;
                end else begin
                  // data byte: write path not modelled, but a cycle is owed
                  wr_pend_r <= 1'b1;
                end
              end
            end
          end
          `ST_ACK_IN: begin
            if (ret_r == `ST_LOAD && !tx_pending_r && buf_in_ready) begin
              fetch_r <= 1'b1;
              tx_pending_r <= 1'b1;
            end
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              state_r <= ret_r;
              if (ret_r == `ST_LOAD) begin
                tx_pending_r <= 1'b0;
                state_r <= `ST_TX;
                sda_out <= buf_data[7];
                sda_oe_n <= buf_data[7];
                shift_r <= {buf_data[6:0], 1'b1};
                pop_r <= 1'b1;
                bit_r <= 4'h1;
                addr_r <= next_addr(addr_r);
              end
            end
          end
          `ST_TX: begin
            if (scl_fall) begin
              if (bit_r == 4'h8) begin
                sda_oe_n <= 1'b1;
                sda_out <= 1'b1;
                state_r <= `ST_ACK_OUT;
              end else begin
                sda_out <= shift_r[7];
                sda_oe_n <= shift_r[7];
                shift_r <= {shift_r[6:0], 1'b1};
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          `ST_ACK_OUT: begin
            if (scl_rise) begin
              if (!sda_r) begin
                state_r <= `ST_ACK_IN;
                ret_r <= `ST_LOAD;
              end else begin
                state_r <= `ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= `ST_IDLE;
          end
        endcase
      end
    end
  end
  // address rollover above DEPTH for small variant: upper bit kept, counter runs on
  wire unused_depth = (DEPTH == 0);
endmodule

// ---- tb/bus_ctl.sv ----
// behavioural i2c bus controller that clocks and drives the serial link
`timescale 1ns/1ps
module bus_ctl (
  input wire clock,
  input wire sda,
  output logic scl,
  output logic sda_low
);
  logic [7:0] obs;
  int slow;
  event got;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    slow = 0;
  end
  // quarter bit; slow stretches scl as a stalling controller would
  task q;
    repeat (2 + slow) @(negedge clock);
  endtask
  task start;
    sda_low = 1'b0;
    q;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask
  task stop;
    sda_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b0;
    q;
    q;
  endtask
  task bitx(input logic b, output logic r);
    sda_low = !b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask
  task xfer(input logic [7:0] d, input logic ai, input logic rd);
    logic [7:0] r;
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(ai, a);
    obs = rd ? r : {7'h00, a};
    -> got;
  endtask
endmodule

// ---- tb/eeprom_read_path_properties.sv ----
// pin-level assertions for the eeprom read path
`timescale 1ns/1ps
module eeprom_read_path_chk #(
  parameter WRITE_CYCLES = 200
) (
  input logic clock,
  input logic resetn,
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe_n,
  input logic busy
);
  localparam int BMAX = WRITE_CYCLES + 4;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
  sequence s_stop; scl_in && $past(scl_in) && $rose(sda_in); endsequence
  sequence s_scl_high; scl_in [*4]; endsequence
  property p_drive_low; !sda_oe_n |-> !sda_out; endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda driven high");
  property p_edge_low; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_edge_low: assert property (p_edge_low) else $error("sda moved, scl high");
  property p_hold_high; s_scl_high |-> $stable(sda_oe_n); endproperty
  a_hold_high: assert property (p_hold_high) else $error("sda unstable");
  property p_start_free; s_start |-> sda_oe_n [*8]; endproperty
  a_start_free: assert property (p_start_free) else $error("drive after start");
  property p_stop_free; s_stop |-> sda_oe_n [*8]; endproperty
  a_stop_free: assert property (p_stop_free) else $error("drive after stop");
  property p_busy_quiet; busy |-> sda_oe_n; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
  property p_busy_hold; $rose(busy) |-> busy [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_busy_end; $rose(busy) |-> ##[1:BMAX] !busy; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy too long");
  property p_busy_at_stop; $rose(busy) |-> scl_in && sda_in; endproperty
  a_busy_at_stop: assert property (p_busy_at_stop) else $error("busy off stop");
endmodule
bind eeprom_read_path eeprom_read_path_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .busy(busy));

// ---- tb/eeprom_read_path_tb.sv ----
// self-checking bench for the eeprom read path
`timescale 1ns/1ps
module eeprom_read_path_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic scl, m_low, sda_out, sda_oe_n, busy;
  // pulled-up wire: low if either side pulls
  wire sda = !((!sda_oe_n && !sda_out) || m_low);
  logic [7:0] expq[$];
  int bad_count = 0;
  int tests_run = 0;
  always #12.5 clock = ~clock;
  eeprom_read_path #(.SMALL_VARIANT(0), .WRITE_CYCLES(200)) u_eeprom_read_path (.clock(clock),
    .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .busy(busy));
  bus_ctl u_bus_ctl (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task op(input logic [7:0] d, input logic ai, input logic rd, input logic [7:0] e);
    expq.push_back(e);
    u_bus_ctl.xfer(d, ai, rd);
  endtask
  task rd_tail(input int n);
    for (int k = 0; k < n; k++) op(8'hff, 1'b0, 1'b1, 8'hff);
    op(8'hff, 1'b1, 1'b1, 8'hff);
    u_bus_ctl.stop;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(u_bus_ctl.got) check("sda_byte", u_bus_ctl.obs, expq.pop_front());
  initial begin
    #400000;
    bad_count++;
    final_report;
  end
  initial begin : main
    int i;
    void'($urandom(32'hd5f85a60));
    repeat (16) @(negedge clock);
    resetn = 1'b1;
    repeat (8) @(negedge clock);
    u_bus_ctl.start;
    op(8'ha1, 1'b1, 1'b0, 8'h00);
    rd_tail(2);
    for (i = 1; i < 8; i++) begin
      u_bus_ctl.start;
      op(8'ha1 ^ (8'h01 << i), 1'b1, 1'b0, 8'h01);
      u_bus_ctl.stop;
    end
    // selective reads, last one from the top location; stalls grow
    for (i = 0; i < 3; i++) begin
      u_bus_ctl.slow = i;
      u_bus_ctl.start;
      op(8'ha0, 1'b1, 1'b0, 8'h00);
      op((i == 2) ? 8'hff : 8'($urandom), 1'b1, 1'b0, 8'h00);
      u_bus_ctl.start;
      op(8'ha1, 1'b1, 1'b0, 8'h00);
      rd_tail(i + 1);
      check("busy", {7'h00, busy}, 8'h00);
    end
    u_bus_ctl.start;
    op(8'ha0, 1'b1, 1'b0, 8'h00);
    op(8'h10, 1'b1, 1'b0, 8'h00);
    op(8'h5a, 1'b1, 1'b0, 8'h00);
    u_bus_ctl.stop;
    repeat (8) @(negedge clock);
    check("busy", {7'h00, busy}, 8'h01);
    u_bus_ctl.start;
    op(8'ha1, 1'b1, 1'b0, 8'h01);
    u_bus_ctl.stop;
    for (i = 0; i < 400 && busy === 1'b1; i++) @(negedge clock);
    check("busy", {7'h00, busy}, 8'h00);
    u_bus_ctl.start;
    op(8'ha1, 1'b1, 1'b0, 8'h00);
    rd_tail(0);
    final_report;
  end
endmodule
